//--- dsp_chan.sv
`timescale 1ns/1ps
module dsp_chan
    import dsp_pkg::*;
#(
    parameter int W = 16,
    parameter bit IS_A = 1'b1
)(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic dual_i,
    input wire logic load_i,
    input wire logic up_i,
    input wire logic mode_hi_i,
    input wire logic dir_i,
    input wire logic [1:0] com_i,
    input wire logic [W-1:0] cnt_i,
    input wire logic [W-1:0] top_i,
    input wire logic [W-1:0] buf_i,
    output logic [W-1:0] cmp_o,
    output logic match_o,
    output logic wave_o,
    output logic oe_n_o
);
    logic [W-1:0] cmp_ff;
    logic wave_ff;
    logic oe_n_ff;
    logic lvl;
    logic toggle;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------
    // Active compare register
    // ------------------------------------------------------------
    // Outside the dual-slope modes the buffer passes straight through.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cmp_ff <= '0;
        else if (!dual_i || load_i)
            cmp_ff <= buf_i;
    end
    assign cmp_o = cmp_ff;

    // match, never above TOP
    // A compare beyond TOP could still be met after a capture write
    // left the counter above TOP, so it is excluded explicitly.
    assign match_o = dual_i && tick_i && (cnt_i == cmp_ff)
                     && (cmp_ff <= top_i);

    always_comb
    begin
        if (cnt_i == '0)
            lvl = 1'b0;
        else if (cnt_i == top_i)
            lvl = 1'b1;
        else
            lvl = !up_i;
        if (com_i == DSP_COM_INV)
            lvl = !lvl;
    end

    assign toggle = IS_A && mode_hi_i && (com_i == DSP_COM_TOGGLE);

    // ------------------------------------------------------------
    // Waveform and pin enable
    // ------------------------------------------------------------
    // drive level on match
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            wave_ff <= 1'b0;
        else if (match_o && toggle)
            wave_ff <= !wave_ff;
        else if (match_o && com_i[1])
            wave_ff <= lvl;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            oe_n_ff <= 1'b1;
        else
            oe_n_ff <= !(dir_i && (com_i[1] || toggle));
    end
    assign wave_o = wave_ff;
    assign oe_n_o = oe_n_ff;

    AST_CHAN_NOMATCH: assert property ((cmp_ff > top_i)
        |=> $stable(wave_ff)) else $error("Output moved above TOP.");

    AST_CHAN_UPCLR: assert property ((match_o && up_i
        && com_i == DSP_COM_NONINV && cnt_i != top_i && cnt_i != '0)
        |=> !wave_ff) else $error("Up-count match did not clear output.");
endmodule : dsp_chan

//--- dsp_load_model.sv
`timescale 1ns/1ps
module dsp_load_model
(
    input wire logic wave_i,
    input wire logic oe_n_i,
    output logic pin_o
);
    // ------------------------------------------------------------
    // Pin level seen by the load
    // ------------------------------------------------------------
    // pin driven only
    // The driver input has a pull-down, so a released pin reads low.
    assign pin_o = oe_n_i ? 1'b0 : wave_i;
endmodule : dsp_load_model

//--- dsp_pkg.sv
// How it works
// - Phase-correct TOP: fixed, capture or compare-A.
// - Variable TOP from three up to 16 bits.
// - Count up, hold TOP one tick, count down.
// - Phase-correct overflow flag set at BOTTOM.
// - Phase-correct loads compares at TOP, flags TOP.
// - Fixed TOP masks high compare bits on write.
// - Compare above TOP never matches.
// - Output field 2 non-inverted, 3 inverted.
// - Pin driven only when direction is output.
// - Up match one level, down match opposite.
// - Period is two times N times TOP.
// - Compare at BOTTOM low, at TOP high when non-inverted; field 3 gives the opposite.
// - Frequency-correct TOP: mode 8 capture, 9 compare-A.
// - Frequency-correct loads compares and overflows at BOTTOM.
// - Frequency-correct flags compare-A or capture at TOP.
// - Channel flag set on every compare match, never above TOP.
// - Capture writes immediate, compare-A writes buffered.
// - Field 1 toggles output A when mode bit3.
package dsp_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] DSP_OFS_CTRL = 8'h00;
    localparam logic [7:0] DSP_OFS_COUNT = 8'h04;
    localparam logic [7:0] DSP_OFS_CMPA = 8'h08;
    localparam logic [7:0] DSP_OFS_CMPB = 8'h0c;
    localparam logic [7:0] DSP_OFS_CAPT = 8'h10;
    localparam logic [7:0] DSP_OFS_FLAGS = 8'h14;
    // ------------------------------------------------------------
    // Control field positions and reset values
    // ------------------------------------------------------------
    localparam int DSP_CTRL_MODE = 0;
    localparam int DSP_CTRL_COMA = 4;
    localparam int DSP_CTRL_COMB = 6;
    localparam int DSP_CTRL_DIRA = 8;
    localparam int DSP_CTRL_DIRB = 9;
    localparam int DSP_CTRL_PRE = 10;
    localparam int DSP_CTRL_W = 13;
    localparam logic [12:0] DSP_CTRL_RST = 13'h0000;
    localparam logic [15:0] DSP_REG_RST = 16'h0000;
    localparam int DSP_FLG_OVF = 0;
    localparam int DSP_FLG_CMPA = 1;
    localparam int DSP_FLG_CMPB = 2;
    localparam int DSP_FLG_CAPT = 3;
    // ------------------------------------------------------------
    // Waveform modes and fixed TOP values
    // ------------------------------------------------------------
    localparam logic [3:0] DSP_MODE_PC8 = 4'h1;
    localparam logic [3:0] DSP_MODE_PC9 = 4'h2;
    localparam logic [3:0] DSP_MODE_PC10 = 4'h3;
    localparam logic [3:0] DSP_MODE_PFC_CAP = 4'h8;
    localparam logic [3:0] DSP_MODE_PFC_A = 4'h9;
    localparam logic [3:0] DSP_MODE_PC_CAP = 4'ha;
    localparam logic [3:0] DSP_MODE_PC_A = 4'hb;
    localparam logic [15:0] DSP_TOP_8 = 16'h00ff;
    localparam logic [15:0] DSP_TOP_9 = 16'h01ff;
    localparam logic [15:0] DSP_TOP_10 = 16'h03ff;
    localparam logic [15:0] DSP_TOP_MIN = 16'h0003;
    // ------------------------------------------------------------
    // Compare output modes
    // ------------------------------------------------------------
    localparam logic [1:0] DSP_COM_TOGGLE = 2'h1;
    localparam logic [1:0] DSP_COM_NONINV = 2'h2;
    localparam logic [1:0] DSP_COM_INV = 2'h3;
    // ------------------------------------------------------------
    // Prescaler terminal counts (divider minus one)
    // ------------------------------------------------------------
    localparam logic [9:0] DSP_DIV1_M1 = 10'h000;
    localparam logic [9:0] DSP_DIV8_M1 = 10'h007;
    localparam logic [9:0] DSP_DIV64_M1 = 10'h03f;
    localparam logic [9:0] DSP_DIV256_M1 = 10'h0ff;
    localparam logic [9:0] DSP_DIV1024_M1 = 10'h3ff;
endpackage : dsp_pkg

//--- dsp_timer.sv
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module dsp_timer
    import dsp_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic WAVE_A_O,
    output logic WAVE_A_OE_N_O,
    output logic WAVE_B_O,
    output logic WAVE_B_OE_N_O
);
    logic [DSP_CTRL_W-1:0] ctrl_ff;
    logic [15:0] buf_a_ff;
    logic [15:0] buf_b_ff;
    logic [15:0] capture_top_reg_ff;
    logic [15:0] counter_value_ff;
    logic up_ff;
    logic [3:0] flags_ff;
    logic [9:0] pre_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    logic [3:0] waveform_mode;
    logic [2:0] pre_sel;
    logic [9:0] pre_max;
    logic tick;
    logic pc_fixed;
    logic pc_mode;
    logic pfc_mode;
    logic dual;
    logic top_from_cap;
    logic top_from_a;
    logic [15:0] top;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic match_a;
    logic match_b;
    logic at_top;
    logic at_bot;
    logic load;
    logic [15:0] wmask;
    logic setup;
    logic wr;
    logic hit;
    logic [31:0] rd_val;
    logic [3:0] flag_set;
    logic [3:0] flag_clr;
    default clocking @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    assign waveform_mode = ctrl_ff[DSP_CTRL_MODE +: 4];
    assign pre_sel = ctrl_ff[DSP_CTRL_PRE +: 3];
    assign pc_fixed = (waveform_mode == DSP_MODE_PC8)
                      || (waveform_mode == DSP_MODE_PC9)
                      || (waveform_mode == DSP_MODE_PC10);
    assign top_from_cap = (waveform_mode == DSP_MODE_PC_CAP)
                          || (waveform_mode == DSP_MODE_PFC_CAP);
    assign top_from_a = (waveform_mode == DSP_MODE_PC_A)
                        || (waveform_mode == DSP_MODE_PFC_A);
    assign pfc_mode = (waveform_mode == DSP_MODE_PFC_CAP)
                      || (waveform_mode == DSP_MODE_PFC_A);
    assign pc_mode = pc_fixed || (waveform_mode == DSP_MODE_PC_CAP)
                     || (waveform_mode == DSP_MODE_PC_A);
    assign dual = pc_mode || pfc_mode;

    // TOP source select
    // The variable TOP spans the full 16 bits; keeping it at least
    // three is up to software.
    always_comb
    begin
        case (waveform_mode)
            DSP_MODE_PC8: top = DSP_TOP_8;
            DSP_MODE_PC9: top = DSP_TOP_9;
            DSP_MODE_PC10: top = DSP_TOP_10;
            DSP_MODE_PC_CAP: top = capture_top_reg_ff;
            DSP_MODE_PFC_CAP: top = capture_top_reg_ff;
            DSP_MODE_PC_A: top = cmp_a;
            DSP_MODE_PFC_A: top = cmp_a;
            default: top = '1;
        endcase
    end

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    // divider N per tick
    always_comb
    begin
        case (pre_sel)
            3'h1: pre_max = DSP_DIV1_M1;
            3'h2: pre_max = DSP_DIV8_M1;
            3'h3: pre_max = DSP_DIV64_M1;
            3'h4: pre_max = DSP_DIV256_M1;
            3'h5: pre_max = DSP_DIV1024_M1;
            default: pre_max = DSP_DIV1_M1;
        endcase
    end
    assign tick = (pre_sel >= 3'h1) && (pre_sel <= 3'h5)
                  && (pre_ff == pre_max);

    // A stopped or out-of-range selection parks the divider at zero.
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            pre_ff <= '0;
        else if (tick || pre_sel == 3'h0 || pre_sel > 3'h5)
            pre_ff <= '0;
        else
            pre_ff <= pre_ff + 10'h001;
    end

    // ------------------------------------------------------------
    // Dual-slope counter
    // ------------------------------------------------------------
    assign at_top = tick && dual && up_ff && (counter_value_ff == top);
    assign at_bot = tick && dual && !up_ff && (counter_value_ff == '0);

    // up, hold TOP, down
    // Reaching TOP takes one tick and leaving it the next, so TOP is
    // seen for exactly one timer cycle. A counter left above TOP by a
    // capture write while counting up runs on through the wrap before it turns.
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            counter_value_ff <= DSP_REG_RST;
            up_ff <= 1'b1;
        end
        else if (at_top)
        begin
            counter_value_ff <= counter_value_ff - 16'h0001;
            up_ff <= 1'b0;
        end
        else if (at_bot)
        begin
            counter_value_ff <= counter_value_ff + 16'h0001;
            up_ff <= 1'b1;
        end
        else if (tick && dual && up_ff)
            counter_value_ff <= counter_value_ff + 16'h0001;
        else if (tick && dual)
            counter_value_ff <= counter_value_ff - 16'h0001;
    end

    assign load = pfc_mode ? at_bot : at_top;

    // ------------------------------------------------------------
    // Compare channels
    // ------------------------------------------------------------
    dsp_chan #(.W(16), .IS_A(1'b1)) u_chan_a (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RST_N_I),
        .tick_i(tick),
        .dual_i(dual),
        .load_i(load),
        .up_i(up_ff),
        .mode_hi_i(waveform_mode[3]),
        .dir_i(ctrl_ff[DSP_CTRL_DIRA]),
        .com_i(ctrl_ff[DSP_CTRL_COMA +: 2]),
        .cnt_i(counter_value_ff),
        .top_i(top),
        .buf_i(buf_a_ff),
        .cmp_o(cmp_a),
        .match_o(match_a),
        .wave_o(WAVE_A_O),
        .oe_n_o(WAVE_A_OE_N_O)
    );

    dsp_chan #(.W(16), .IS_A(1'b0)) u_chan_b (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RST_N_I),
        .tick_i(tick),
        .dual_i(dual),
        .load_i(load),
        .up_i(up_ff),
        .mode_hi_i(waveform_mode[3]),
        .dir_i(ctrl_ff[DSP_CTRL_DIRB]),
        .com_i(ctrl_ff[DSP_CTRL_COMB +: 2]),
        .cnt_i(counter_value_ff),
        .top_i(top),
        .buf_i(buf_b_ff),
        .cmp_o(cmp_b),
        .match_o(match_b),
        .wave_o(WAVE_B_O),
        .oe_n_o(WAVE_B_OE_N_O)
    );

    // ------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------
    // flag events
    always_comb
    begin
        flag_set = '0;
        flag_set[DSP_FLG_OVF] = at_bot;
        flag_set[DSP_FLG_CMPA] = match_a || (at_top && top_from_a);
        flag_set[DSP_FLG_CMPB] = match_b;
        flag_set[DSP_FLG_CAPT] = at_top && top_from_cap;
    end

    // Write one to clear; a new event in the same cycle wins.
    assign flag_clr = (wr && PADDR_I == DSP_OFS_FLAGS) ? PWDATA_I[3:0]
                                                       : 4'h0;
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            flags_ff <= '0;
        else
            flags_ff <= (flags_ff & ~flag_clr) | flag_set;
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // No wait state: data is looked up in setup and pready rises
    // for the first access cycle only.
    assign setup = PSEL_I && !PENABLE_I;
    assign wr = PSEL_I && PENABLE_I && PWRITE_I && pready_ff;
    assign hit = (PADDR_I == DSP_OFS_CTRL) || (PADDR_I == DSP_OFS_COUNT)
                 || (PADDR_I == DSP_OFS_CMPA) || (PADDR_I == DSP_OFS_CMPB)
                 || (PADDR_I == DSP_OFS_CAPT)
                 || (PADDR_I == DSP_OFS_FLAGS);

    always_comb
    begin
        rd_val = '0;
        if (PADDR_I == DSP_OFS_CTRL)
            rd_val[DSP_CTRL_W-1:0] = ctrl_ff;
        else if (PADDR_I == DSP_OFS_COUNT)
            rd_val[16:0] = {up_ff, counter_value_ff};
        else if (PADDR_I == DSP_OFS_CMPA)
            rd_val[15:0] = buf_a_ff;
        else if (PADDR_I == DSP_OFS_CMPB)
            rd_val[15:0] = buf_b_ff;
        else if (PADDR_I == DSP_OFS_CAPT)
            rd_val[15:0] = capture_top_reg_ff;
        else if (PADDR_I == DSP_OFS_FLAGS)
            rd_val[3:0] = flags_ff;
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end
        else
        begin
            pready_ff <= setup;
            if (setup)
            begin
                pslverr_ff <= !hit;
                prdata_ff <= PWRITE_I ? 32'h0000_0000 : rd_val;
            end
        end
    end
    assign PREADY_O = pready_ff;
    assign PSLVERR_O = pslverr_ff;
    assign PRDATA_O = prdata_ff;

    assign wmask = pc_fixed ? top : 16'hffff;

    // compare-A buffered, capture immediate
    // Capture has no buffer, so a write below the running count while
    // counting up makes the counter wrap before TOP is met again.
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ctrl_ff <= DSP_CTRL_RST;
            buf_a_ff <= DSP_REG_RST;
            buf_b_ff <= DSP_REG_RST;
            capture_top_reg_ff <= DSP_REG_RST;
        end
        else if (wr)
        begin
            if (PADDR_I == DSP_OFS_CTRL)
                ctrl_ff <= PWDATA_I[DSP_CTRL_W-1:0];
            else if (PADDR_I == DSP_OFS_CMPA)
                buf_a_ff <= PWDATA_I[15:0] & wmask;
            else if (PADDR_I == DSP_OFS_CMPB)
                buf_b_ff <= PWDATA_I[15:0] & wmask;
            else if (PADDR_I == DSP_OFS_CAPT)
                capture_top_reg_ff <= PWDATA_I[15:0];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_TOP_FIXED: assert property ((waveform_mode == DSP_MODE_PC9)
        |-> (top == 16'h01ff)) else $error("Bad nine-bit TOP.");
    AST_TOP_PFC: assert property ((waveform_mode == DSP_MODE_PFC_A)
        |-> (top == cmp_a)) else $error("TOP not from compare-A.");
    AST_TOP_TURN: assert property (at_top |=> (!up_ff
        && counter_value_ff == $past(top) - 16'h0001))
        else $error("Counter did not turn after TOP.");
    AST_OVF_BOT: assert property (at_bot |=> flags_ff[DSP_FLG_OVF]
        && up_ff) else $error("Overflow flag not set at BOTTOM.");
    AST_PC_LOAD: assert property ((at_top && pc_mode)
        |=> (cmp_b == $past(buf_b_ff))) else $error("No compare load at TOP.");
    AST_PFC_LOAD: assert property ((at_bot && pfc_mode) |=>
        (cmp_a == $past(buf_a_ff)) && flags_ff[DSP_FLG_OVF])
        else $error("Compare or overflow not updated at BOTTOM.");
    AST_CAP_FLAG: assert property ((at_top && top_from_cap)
        |=> flags_ff[DSP_FLG_CAPT]) else $error("No capture flag at TOP.");
    AST_MASK: assert property ((wr && PADDR_I == DSP_OFS_CMPA
        && waveform_mode == DSP_MODE_PC8) |=> (buf_a_ff[15:8] == 8'h00))
        else $error("High compare bits not masked.");
    AST_CAP_IMM: assert property ((wr && PADDR_I == DSP_OFS_CAPT)
        |=> (capture_top_reg_ff == $past(PWDATA_I[15:0])))
        else $error("Capture write did not take effect at once.");
    AST_PIN_OFF: assert property (!ctrl_ff[DSP_CTRL_DIRA] [*2]
        |-> WAVE_A_OE_N_O) else $error("Pin driven while direction is input.");
    AST_TICK_ONLY: assert property (!tick
        |=> $stable(counter_value_ff))
        else $error("Counter moved without a timer tick.");
endmodule : dsp_timer

//--- dual_slope_pwm_timer16_bench.sv
`timescale 1ns/1ps
module dual_slope_pwm_timer16_bench
    import dsp_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] padr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic prdy, perr, wa, oea, wb, oeb, pin_a, pin_b;
    logic [31:0] n;
    int mismatches = 0;
    int checks_done = 0;
    dsp_timer dsp_timer_i (.SYS_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
        .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr), .WAVE_A_O(wa),
        .WAVE_A_OE_N_O(oea), .WAVE_B_O(wb), .WAVE_B_OE_N_O(oeb));
    dsp_load_model load_a_i (.wave_i(wa), .oe_n_i(oea), .pin_o(pin_a));
    dsp_load_model load_b_i (.wave_i(wb), .oe_n_i(oeb), .pin_o(pin_b));
    // ------------------------------------------------------------
    // Clock and shared tasks
    // ------------------------------------------------------------
    // A 10 ns period clock.
    initial
    begin
        forever #5 clk = ~clk;
    end
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Holds the request until PREADY is sampled high, as APB demands.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (prdy !== 1'b1 && k < 40);
        if (k >= 40)
            check(32'h1, 32'h0);
        q = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, x);
        check({31'h0, e}, {31'h0, xe});
    endtask : rdc
    function automatic logic [31:0] ctl(input logic [3:0] m,
        input logic [1:0] ca, input logic [1:0] cb, input logic [1:0] dr,
        input logic [2:0] p);
        ctl = {19'h0, p, dr, cb, ca, m};
    endfunction : ctl
    task do_reset;
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset
    // Counts high pin cycles over two periods after two periods settle.
    task hi(input logic b, input int per, output logic [31:0] c);
        c = 32'h0;
        repeat (2 * per) @(posedge clk);
        repeat (2 * per)
        begin
            @(posedge clk);
            c = c + {31'h0, b ? pin_b : pin_a};
        end
    endtask : hi
    task setup(input logic [15:0] cap, input logic [15:0] ca,
               input logic [15:0] cb, input logic [31:0] c);
        do_reset();
        wr(DSP_OFS_CAPT, {16'h0, cap});
        wr(DSP_OFS_CMPA, {16'h0, ca});
        wr(DSP_OFS_CMPB, {16'h0, cb});
        wr(DSP_OFS_CTRL, c);
    endtask : setup
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        do_reset();
        check({30'h0, oea, oeb}, 32'h3);
        rdc(DSP_OFS_CTRL, 32'h0, 1'b0);
        wr(DSP_OFS_COUNT, 32'h5);
        rdc(DSP_OFS_COUNT, 32'h10000, 1'b0);
        rdc(DSP_OFS_FLAGS, 32'h0, 1'b0);
        rdc(8'h20, 32'h0, 1'b1);
        wr(DSP_OFS_CTRL, 32'h1fff);
        rdc(DSP_OFS_CTRL, 32'h1fff, 1'b0);
        $display("test reset done");
    endtask : t_reset
    task t_pc;
        // Capture as TOP with a fixed frequency is the preferred use.
        // fixed capture top
        setup(16'h7, 16'h0, 16'h3, ctl(DSP_MODE_PC_CAP, 2'h0,
              DSP_COM_NONINV, 2'b10, 3'h1));
        hi(1'b1, 14, n);
        check(n, 32'd12);
        wr(DSP_OFS_CTRL, ctl(DSP_MODE_PC_CAP, 2'h0, DSP_COM_INV, 2'b10, 3'h1));
        hi(1'b1, 14, n);
        check(n, 32'd16);
        wr(DSP_OFS_CTRL, ctl(DSP_MODE_PC_CAP, 2'h0, DSP_COM_INV, 2'b10, 3'h0));
        rdc(DSP_OFS_FLAGS, 32'hf, 1'b0);
        wr(DSP_OFS_FLAGS, 32'hf);
        rdc(DSP_OFS_FLAGS, 32'h0, 1'b0);
        setup(16'h7, 16'h0, 16'h3, ctl(DSP_MODE_PC_CAP, 2'h0,
              DSP_COM_NONINV, 2'b10, 3'h2));
        hi(1'b1, 112, n);
        check(n, 32'd96);
        $display("test phase correct done");
    endtask : t_pc
    task t_pfc;
        setup(16'h0, 16'h3, 16'h1, ctl(DSP_MODE_PFC_A, 2'h0,
              DSP_COM_NONINV, 2'b10, 3'h1));
        hi(1'b1, 6, n);
        check(n, 32'd4);
        wr(DSP_OFS_CMPA, 32'h5);
        hi(1'b1, 10, n);
        check(n, 32'd4);
        setup(16'h5, 16'h0, 16'h2, ctl(DSP_MODE_PFC_CAP, 2'h0,
              DSP_COM_NONINV, 2'b10, 3'h1));
        hi(1'b1, 10, n);
        check(n, 32'd8);
        wr(DSP_OFS_CTRL, 32'h0);
        rdc(DSP_OFS_FLAGS, 32'hf, 1'b0);
        $display("test frequency correct done");
    endtask : t_pfc
    task t_level(input logic [15:0] cb, input logic d, input logic [31:0] x,
                 input logic [31:0] f);
        setup(16'h7, 16'h0, cb, ctl(DSP_MODE_PC_CAP, 2'h0, DSP_COM_NONINV,
              {d, 1'b0}, 3'h1));
        hi(1'b1, 14, n);
        check(n, x);
        wr(DSP_OFS_CTRL, 32'h0);
        rdc(DSP_OFS_FLAGS, f, 1'b0);
        $display("test level done");
    endtask : t_level
    task t_mask;
        do_reset();
        wr(DSP_OFS_CTRL, ctl(DSP_MODE_PC10, 2'h0, 2'h0, 2'b00, 3'h0));
        wr(DSP_OFS_CMPB, 32'hffff);
        rdc(DSP_OFS_CMPB, 32'h3ff, 1'b0);
        wr(DSP_OFS_CTRL, ctl(DSP_MODE_PC9, 2'h0, 2'h0, 2'b00, 3'h0));
        wr(DSP_OFS_CMPB, 32'hffff);
        rdc(DSP_OFS_CMPB, 32'h1ff, 1'b0);
        wr(DSP_OFS_CTRL, ctl(DSP_MODE_PC8, 2'h0, 2'h0, 2'b00, 3'h0));
        wr(DSP_OFS_CMPA, 32'h1234);
        rdc(DSP_OFS_CMPA, 32'h34, 1'b0);
        wr(DSP_OFS_CTRL, ctl(DSP_MODE_PC8, DSP_COM_NONINV, 2'h0, 2'b01, 3'h1));
        hi(1'b0, 510, n);
        check(n, 32'd208);
        $display("test fixed top done");
    endtask : t_mask
    task t_pca;
        setup(16'h0, 16'h5, 16'h2, ctl(DSP_MODE_PC_A, DSP_COM_TOGGLE,
              DSP_COM_NONINV, 2'b11, 3'h1));
        hi(1'b0, 10, n);
        check(n, 32'd10);
        hi(1'b1, 10, n);
        check(n, 32'd8);
        wr(DSP_OFS_CTRL, ctl(DSP_MODE_PC_A, DSP_COM_TOGGLE, DSP_COM_TOGGLE,
           2'b11, 3'h0));
        rdc(DSP_OFS_FLAGS, 32'h7, 1'b0);
        check({30'h0, oea, oeb}, 32'h1);
        $display("test compare-A top done");
    endtask : t_pca
    task t_pre;
        for (int i = 3; i <= 5; i++)
        begin
            setup(16'h3, 16'h0, 16'h1, ctl(DSP_MODE_PC_CAP, 2'h0,
                  DSP_COM_NONINV, 2'b10, i[2:0]));
            hi(1'b1, 6 << (2 * i), n);
            check(n, 32'd4 << (2 * i));
        end
        $display("test dividers done");
    endtask : t_pre
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    // Runs every scenario, then gives the verdict.
    initial
    begin
        t_reset();
        t_pc();
        t_pfc();
        t_level(16'h0, 1'b1, 32'd0, 32'hf);
        t_level(16'h7, 1'b1, 32'd28, 32'hf);
        t_level(16'h9, 1'b1, 32'd0, 32'hb);
        t_level(16'h7, 1'b0, 32'd0, 32'hf);
        t_mask();
        t_pca();
        t_pre();
        test_done();
    end
    // The run needs about 36000 cycles; this limit leaves wide margin.
    initial
    begin
        #600000;
        mismatches++;
        test_done();
    end
endmodule : dual_slope_pwm_timer16_bench
